// ### rtl/power_on_self_test_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "post_seq_defines.vh"
module power_on_self_test_sequencer #(
  parameter FLASH_CYC   = `FLASH_SEC * `CLK_HZ,
  parameter LONG_CYC    = `LONG_TEST_SEC * `CLK_HZ,
  parameter HALF_CYC    = `FLASH_HALF_MS * (`CLK_HZ / 1000),
  parameter ROT_CYC     = `ROTATE_MS * (`CLK_HZ / 1000),
  parameter CAR_CYC     = `CARRIER_BASE_MS * (`CLK_HZ / 1000),
  parameter SHORT_CYC   = 16
) (
  input  wire       clock,
  input  wire       rstn,
  input  wire       clk_en,
  input  wire       link_connected,
  input  wire       carrier_present,
  input  wire       run_once_req,
  input  wire       test_done,
  input  wire       test_fail,
  output reg  [3:0] led,
  output reg        carrier_led,
  output reg  [3:0] test_num,
  output reg        test_start,
  output reg        tx_inhibit,
  output reg        err_valid,
  output reg  [7:0] err_decimal
);

// ************************************************************
// Input synchronisers
// ************************************************************
reg [1:0] link_sync_ff;
reg [1:0] car_sync_ff;
reg [1:0] req_sync_ff;
reg       req_last_ff;
wire      link_s = link_sync_ff[1];
wire      car_s  = car_sync_ff[1];
wire      req_rise = req_sync_ff[1] & ~req_last_ff;

// Two flops each; only stage two feeds logic
always @(posedge clock or negedge rstn) begin
  if (!rstn) begin
    link_sync_ff <= 2'h0;
    car_sync_ff  <= 2'h0;
    req_sync_ff  <= 2'h0;
    req_last_ff  <= 1'b0;
  end else if (clk_en) begin
    link_sync_ff <= {link_sync_ff[0], link_connected};
    car_sync_ff  <= {car_sync_ff[0], carrier_present};
    req_sync_ff  <= {req_sync_ff[0], run_once_req};
    req_last_ff  <= req_sync_ff[1];
  end
end

// ************************************************************
// Test sequencer
// ************************************************************
localparam S_RUN   = 5'h01;
localparam S_WAIT  = 5'h02;
localparam S_HALT  = 5'h04;
localparam S_FLASH = 5'h08;
localparam S_IDLE  = 5'h10;

reg [4:0]  state_ff;
reg [33:0] tmr_ff;
reg        once_ff;
reg [31:0] half_ff;
reg        blink_ff;
reg [31:0] rot_cnt_ff;
reg [3:0]  rot_ff;
wire       fatal = (test_num <= `LAST_FATAL);
// Soft tests 10..12 carry labels 12..14, sent as two digits
wire [3:0] soft_digit = test_num - 4'h8;
wire [3:0] num_rev = {test_num[0], test_num[1], test_num[2], test_num[3]};

// One always block: sequence, flash timer and test outputs move together; LEDs and blink/rotate timers have their own blocks
always @(posedge clock or negedge rstn) begin
  if (!rstn) begin
    state_ff    <= S_RUN;
    test_num    <= `FIRST_TEST;
    test_start  <= 1'b0;
    tmr_ff      <= 34'h0;
    once_ff     <= 1'b0;
    tx_inhibit  <= 1'b0;
    err_valid   <= 1'b0;
    err_decimal <= 8'h00;
  end else if (clk_en) begin
    test_start <= 1'b0;
    err_valid  <= 1'b0;
    case (state_ff)
      S_RUN: begin
        test_start <= 1'b1;
        tmr_ff     <= 34'h0;
        state_ff   <= S_WAIT;
      end
      S_WAIT: begin
        tmr_ff <= tmr_ff + 34'h1;
        if (test_done) begin
          if (test_fail && fatal) begin
            state_ff   <= S_HALT;
            tx_inhibit <= 1'b1;
          end else if (test_fail) begin
            err_valid   <= 1'b1;
            err_decimal <= {4'h1, soft_digit};
            tmr_ff      <= 34'h0;
            state_ff    <= S_FLASH;
          end else if (test_num == `LAST_TEST) begin
            state_ff <= (link_s || once_ff) ? S_IDLE : S_RUN;
            test_num <= (link_s || once_ff) ? test_num : `FIRST_TEST;
            once_ff  <= 1'b0;
          end else begin
            test_num <= test_num + 4'h1;
            state_ff <= S_RUN;
          end
        end
      end
      S_HALT: begin
        state_ff <= S_HALT;
      end
      S_FLASH: begin
        tmr_ff <= tmr_ff + 34'h1;
        if (tmr_ff >= FLASH_CYC - 1) begin
          if (test_num == `LAST_TEST) begin
            state_ff <= (link_s || once_ff) ? S_IDLE : S_RUN;
            test_num <= (link_s || once_ff) ? test_num : `FIRST_TEST;
            once_ff  <= 1'b0;
          end else begin
            test_num <= test_num + 4'h1;
            state_ff <= S_RUN;
          end
        end
      end
      S_IDLE: begin
        if (req_rise) begin
          once_ff  <= 1'b1;
          test_num <= `FIRST_TEST;
          state_ff <= S_RUN;
        end else if (!link_s) begin
          test_num <= `FIRST_TEST;
          state_ff <= S_RUN;
        end
      end
      default: begin
        state_ff <= S_RUN;
      end
    endcase
  end
end

// ************************************************************
// Display and carrier LED
// ************************************************************
// Blink and rotate timebases
always @(posedge clock or negedge rstn) begin
  if (!rstn) begin
    half_ff    <= 32'h0;
    blink_ff   <= 1'b0;
    rot_cnt_ff <= 32'h0;
    rot_ff     <= 4'hE;
  end else if (clk_en) begin
    half_ff <= (half_ff >= HALF_CYC - 1) ? 32'h0 : half_ff + 32'h1;
    if (half_ff >= HALF_CYC - 1) begin
      blink_ff <= ~blink_ff;
    end
    rot_cnt_ff <= (rot_cnt_ff >= ROT_CYC - 1) ? 32'h0 : rot_cnt_ff + 32'h1;
    if (rot_cnt_ff >= ROT_CYC - 1) begin
      rot_ff <= {rot_ff[0], rot_ff[3:1]};
    end
  end
end

// LED 3 is leftmost
always @(posedge clock or negedge rstn) begin
  if (!rstn) begin
    led <= 4'h0;
  end else if (clk_en) begin
    if (state_ff == S_IDLE) begin
      led <= rot_ff;
    end else if (state_ff == S_FLASH) begin
      led <= blink_ff ? num_rev : 4'h0;
    end else begin
      led <= num_rev;
    end
  end
end

// ************************************************************
// Carrier indicator
// ************************************************************
reg [31:0] car_cnt_ff;
reg [31:0] car_period_ff;
reg [15:0] act_ff;
// Base period plus 256 cycles per flash already shown
wire [33:0] car_sum = CAR_CYC + {10'h0, act_ff, 8'h00};

// more activity stretches the flash period
always @(posedge clock or negedge rstn) begin
  if (!rstn) begin
    car_cnt_ff    <= 32'h0;
    car_period_ff <= 32'h0;
    act_ff        <= 16'h0;
    carrier_led   <= 1'b0;
  end else if (clk_en) begin
    if (!car_s) begin
      carrier_led <= 1'b0;
      car_cnt_ff  <= 32'h0;
      act_ff      <= 16'h0;
    end else begin
      car_period_ff <= car_sum[31:0];
      if (car_cnt_ff >= car_period_ff) begin
        car_cnt_ff  <= 32'h0;
        carrier_led <= ~carrier_led;
        // Growing per flash, not per cycle, so the counter can still catch up
        act_ff      <= (act_ff == 16'hFFFF) ? act_ff : act_ff + 16'h1;
      end else begin
        car_cnt_ff <= car_cnt_ff + 32'h1;
      end
    end
  end
end

endmodule
`default_nettype wire

// ### rtl/post_seq_defines.vh
// Functional notes
// - At power-up, run twelve built-in tests automatically.
// - Link connected runs once; otherwise repeat unless a fatal error stops it.
// - Show the running test number on four LEDs.
// - Tests 1..11 octal fatal; on failure loop there, holding that number.
// - After a fatal failure, block every network transmit attempt.
// - Tests 12..14 octal non-fatal; network traffic stays enabled.
// - Non-fatal failure flashes failed number on LEDs for ten seconds.
// - Non-fatal failure sends error number in decimal to operator terminal.
// - Test 13 octal lasts about eleven seconds, shown steady unless failed; sequencer does not time it (LONG_CYC unused), it waits for test_done.
// - No failures and link connected: one dark LED rotates left to right.
// - Carrier LED flashes with carrier present, slower as activity rises.
// - Host exerciser may command one run; device then runs sequence once.
// - Displayed number in binary, least significant bit on leftmost LED.
`ifndef POST_SEQ_DEFINES_VH
`define POST_SEQ_DEFINES_VH
`define FIRST_TEST      4'h1
`define LAST_FATAL      4'h9
`define LAST_TEST       4'hC
`define LONG_TEST       4'hB
`define FLASH_SEC       34'hA
`define LONG_TEST_SEC   34'hB
`define CLK_HZ          34'hEE6B280
`define FLASH_HALF_MS   34'hFA
`define ROTATE_MS       34'hFA
`define CARRIER_BASE_MS 34'h32
`endif

// ### tb/post_seq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Sequencer port checker
// ****
module post_seq_monitor (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       clk_en,
  input wire logic       link_connected,
  input wire logic       carrier_present,
  input wire logic       run_once_req,
  input wire logic       test_done,
  input wire logic       test_fail,
  input wire logic       carrier_led,
  input wire logic       test_start,
  input wire logic       tx_inhibit,
  input wire logic       err_valid,
  input wire logic [3:0] led,
  input wire logic [3:0] test_num,
  input wire logic [7:0] err_decimal
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Engine answers, split by test class
  sequence s_pass; test_done && !test_fail && test_num != 4'hC; endsequence
  sequence s_fatal; test_done && test_fail && test_num <= 4'h9; endsequence
  sequence s_soft; test_done && test_fail && test_num > 4'h9; endsequence
  a_led_num: assert property (test_start |=> led == {test_num[0], test_num[1], test_num[2], test_num[3]})
    else $error("led does not show the test number");
  a_step_up: assert property ($changed(test_num) |-> test_num == $past(test_num) + 4'h1 || test_num == 4'h1)
    else $error("test number skipped");
  a_pass_next: assert property (s_pass |-> ##2 test_start)
    else $error("next test not started");
  a_fatal_block: assert property (s_fatal |-> ##[1:2] tx_inhibit)
    else $error("transmit not blocked");
  a_halt_hold: assert property (tx_inhibit |=> tx_inhibit && !test_start && $stable(test_num))
    else $error("fatal halt left");
  a_soft_open: assert property (s_soft |=> !tx_inhibit [*4])
    else $error("soft failure blocked transmit");
  a_soft_report: assert property (s_soft |-> ##[1:2] err_valid)
    else $error("soft failure not reported");
  a_flash_hold: assert property (s_soft |=> !test_start [*8])
    else $error("flash period cut short");
  a_err_code: assert property (err_valid |-> err_decimal[7:4] == 4'h1 && err_decimal[3:0] inside {[4'h2:4'h4]})
    else $error("bad error number");
endmodule
bind power_on_self_test_sequencer post_seq_monitor mon_i (.clock(clock), .rstn(rstn), .clk_en(clk_en),
  .link_connected(link_connected), .carrier_present(carrier_present), .run_once_req(run_once_req),
  .test_done(test_done), .test_fail(test_fail), .carrier_led(carrier_led), .test_start(test_start),
  .tx_inhibit(tx_inhibit), .err_valid(err_valid), .led(led), .test_num(test_num),
  .err_decimal(err_decimal));
`default_nettype wire

// ### tb/test_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Test engine partner
// ****
module test_engine_model (
  input wire logic       clock, rstn, test_start,
  input wire logic [3:0] test_num, fail_num, delay,
  output var logic       test_done = 1'b0,
  output var logic       test_fail = 1'b0
);
  // Fail flag is junk outside the done pulse, so nothing may lean on it
  always @(posedge clock) begin
    if (test_start && rstn) begin
      repeat (delay) @(posedge clock);
      test_done <= 1'b1;
      test_fail <= test_num == fail_num;
      @(posedge clock);
      test_done <= 1'b0;
      test_fail <= ~test_fail;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Sequencer bench
// ****
module tb;
  logic clock = 0, rstn = 0, link = 0, carrier = 0, run_req = 0, clk_en = 1, car_hold = 0, cl_prev;
  logic [3:0] fail_num = 0, delay = 0, led, test_num, prev;
  logic done, fail, carrier_led, test_start, tx_inhibit, err_valid;
  logic [7:0] err_decimal;
  int mismatches = 0, cmp_count = 0, exp_next = 1, starts = 0, errs = 0, n;
  int gaps [3];
  power_on_self_test_sequencer #(.FLASH_CYC(20), .LONG_CYC(10), .HALF_CYC(4), .ROT_CYC(4), .CAR_CYC(4))
    power_on_self_test_sequencer_i (.clock(clock), .rstn(rstn), .clk_en(clk_en), .link_connected(link),
    .carrier_present(carrier), .run_once_req(run_req), .test_done(done), .test_fail(fail), .led(led),
    .carrier_led(carrier_led), .test_num(test_num), .test_start(test_start), .tx_inhibit(tx_inhibit),
    .err_valid(err_valid), .err_decimal(err_decimal));
  test_engine_model test_engine_model_i (.clock(clock), .rstn(rstn), .test_start(test_start),
    .test_num(test_num), .fail_num(fail_num), .delay(delay), .test_done(done), .test_fail(fail));
  initial forever #2 clock = ~clock;
  // Watchdog: whole run is a few thousand cycles
  initial begin
    #100000;
    mismatches++;
    complete_run;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic restart(input logic l, input logic [3:0] f);
    @(posedge clock);
    rstn <= 1'b0;
    link <= l;
    fail_num <= f;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
  endtask
  // Random engine latency and carrier noise
  always @(posedge clock) begin
    delay <= 4'($urandom_range(0, 3));
    carrier <= car_hold | ($urandom_range(0, 7) == 0);
  end
  // Reference order model, sampled mid-cycle once outputs settle
  always @(negedge clock) begin
    if (!rstn) begin
      exp_next = 1;
      starts = 0;
    end else if (test_start) begin
      check(8'(test_num), 8'(exp_next), "test_num");
      starts++;
      exp_next = exp_next % 12 + 1;
    end
    if (rstn && err_valid) begin
      errs++;
      check(err_decimal, 8'h10 + 8'(fail_num) - 8'h08, "err_decimal");
    end
  end
  initial begin
    void'($urandom(32'h79d4));
    restart(1'b1, 4'h0);
    for (n = 0; n < 9000 && starts < 12; n++) @(negedge clock);
    for (n = 0; n < 900 && led !== 4'hE; n++) @(negedge clock);
    repeat (4) begin
      prev = led;
      for (n = 0; n < 90 && led === prev; n++) @(negedge clock);
      check(8'(led), 8'({prev[0], prev[3:1]}), "idle led");
    end
    // Low clock enable must freeze the idle pattern
    @(posedge clock) clk_en <= 1'b0;
    @(negedge clock) prev = led;
    repeat (20) @(negedge clock);
    check(8'(led), 8'(prev), "frozen led");
    @(posedge clock) clk_en <= 1'b1;
    // Held carrier: flashes go on, third gap longer than the second
    @(posedge clock) car_hold <= 1'b1;
    for (int g = 0; g < 3; g++) begin
      cl_prev = carrier_led;
      for (n = 0; n < 2000 && carrier_led === cl_prev; n++) @(negedge clock);
      gaps[g] = n;
    end
    car_hold <= 1'b0;
    check(8'(gaps[1] < 2000), 8'h01, "carrier flashes");
    check(8'(gaps[2] > gaps[1]), 8'h01, "carrier slows");
    check(8'(starts), 8'd12, "single run");
    @(posedge clock) run_req <= 1'b1;
    repeat (4) @(posedge clock);
    run_req <= 1'b0;
    for (n = 0; n < 9000 && starts < 24; n++) @(negedge clock);
    repeat (200) @(negedge clock);
    check(8'(starts), 8'd24, "commanded run");
    @(posedge clock) link <= 1'b0;
    for (n = 0; n < 9000 && starts < 30; n++) @(negedge clock);
    check(8'(starts), 8'd30, "repeat run");
    for (int f = 10; f <= 12; f++) begin
      restart(1'b0, 4'(f));
      for (n = 0; n < 9000 && starts < 13; n++) @(negedge clock);
      check(8'(tx_inhibit), 8'h00, "soft tx_inhibit");
    end
    check(8'(errs), 8'd3, "error reports");
    restart(1'b1, 4'($urandom_range(1, 9)));
    repeat (300) @(negedge clock);
    check(8'(test_num), 8'(fail_num), "halted test");
    check(8'(starts), 8'(fail_num), "halted starts");
    check(8'(tx_inhibit), 8'h01, "fatal tx_inhibit");
    check(8'({led[0], led[1], led[2], led[3]}), 8'(fail_num), "halted led");
    complete_run;
  end
endmodule
`default_nettype wire
